// file: clock_timer_setup.sv
// Purpose: Second setup register with clock multiplier sequencing and timer selection.
// Assumes: Host requests are one-cycle strobes from logic on the same clock.
// Notes:   Reads of other addresses answer zero; this block only owns two addresses.
//          A clock code change halts the core until the restart command.
//          Reserved clock codes keep the PLL off.
module clock_timer_setup #(
    parameter int unsigned TIMEOUT_420_CYC  = clock_timer_setup_pkg::TIMEOUT_420_CYCLES,
    parameter int unsigned TIMEOUT_105_CYC  = clock_timer_setup_pkg::TIMEOUT_105_CYCLES,
    parameter int unsigned TIMEOUT_52P5_CYC = clock_timer_setup_pkg::TIMEOUT_52P5_CYCLES,
    parameter int unsigned TIMEOUT_26_CYC   = clock_timer_setup_pkg::TIMEOUT_26_CYCLES
) (
    // Clock, reset and host requests.
    input  wire logic                                    clock,
    input  wire logic                                    rstn,
    input  wire clock_timer_setup_pkg::host_req_t        host_req,

    // Line status and RAM init requests.
    input  wire logic                                    line_idle,
    input  wire logic                                    ram_init_request,

    // Read answers.
    output logic [7:0]                                   read_data,
    output logic                                         read_valid,

    // Stored setup fields.
    output logic                                         fast_read_timing_enable,
    output logic                                         clock_multiplier_sel_hi,
    output logic                                         clock_multiplier_sel_lo,
    output logic                                         enhanced_features_enable,
    output logic                                         idle_line_wait_disable,
    output logic                                         reconfig_timeout_sel_hi,
    output logic                                         reconfig_timeout_sel_lo,

    // Sequencing, RAM init and timeout.
    output logic                                         pll_power_up,
    output logic                                         pll_locked,
    output logic                                         clock_40mhz_select,
    output logic                                         core_halted,
    output logic                                         ram_init_start,
    output logic [clock_timer_setup_pkg::TIMEOUT_WIDTH-1:0] reconfig_timeout_cycles
);
    import clock_timer_setup_pkg::*;

    // Last lock count; the PLL counts as locked after it.
    // Twelve bits hold the lock span with room to spare.
    localparam logic [11:0] LOCK_LAST = 12'(PLL_LOCK_CYCLES - 1);

    // Maps a timer code to its timeout in clock cycles.
    // The counts are those for 5 Mbps.
    function automatic logic [TIMEOUT_WIDTH-1:0] timeout_of(input logic [1:0] code);
        logic [TIMEOUT_WIDTH-1:0] result;
        result = '0;
        // Every code has a count.
        case (code)
            2'h0: result = TIMEOUT_WIDTH'(TIMEOUT_420_CYC);
            2'h1: result = TIMEOUT_WIDTH'(TIMEOUT_105_CYC);
            2'h2: result = TIMEOUT_WIDTH'(TIMEOUT_52P5_CYC);
            default: result = TIMEOUT_WIDTH'(TIMEOUT_26_CYC);
        endcase
        return result;
    endfunction

    // Decodes a write strobe to a given address.
    // Both decoders share the same select rules.
    function automatic logic write_to(input host_req_t req, input logic [2:0] addr);
        return req.select && req.write && (req.addr == addr);
    endfunction

    // Stored register and core state.
    logic [7:0]   setup_reg;
    core_state_t  state_reg;
    logic [11:0]  lock_count_reg;
    logic         restart_pending_reg;

    // Stage for normal read timing.
    logic [7:0]   read_stage_reg;
    logic         read_stage_valid_reg;

    // A RAM init request still waiting.
    logic         init_pending_reg;

    // Decoded requests of this cycle.
    // They are valid only while the strobe stands.
    logic         setup_write;
    logic         command_write;
    logic         clock_change;
    logic [1:0]   new_clock_sel;

    // Value of the addressed register.
    logic [7:0]   read_value;

    // Writes ignore the fast read bit.
    assign setup_write   = write_to(host_req, SETUP_ADDR);

    // Other command bytes are ignored.
    assign command_write = write_to(host_req, COMMAND_ADDR) && (host_req.wdata == RESTART_CMD);

    // A change is a write with a new code.
    assign new_clock_sel = {host_req.wdata[CLK_SEL_HI_BIT], host_req.wdata[CLK_SEL_LO_BIT]};
    assign clock_change  = setup_write &&
                           (new_clock_sel != {setup_reg[CLK_SEL_HI_BIT], setup_reg[CLK_SEL_LO_BIT]});

    // Setup register storage; bit 6 is never stored so nothing depends on it.
    // All fields land in the write cycle.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            setup_reg <= SETUP_RESET;
        end else if (setup_write) begin
            // The reserved bit reads as zero.
            setup_reg <= host_req.wdata & ~(8'h01 << RESERVED_BIT);
        end
    end

    // Field outputs mirror the stored register.
    // Outputs come from flip-flops,
    // one cycle behind the register.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // All fields reset to zero.
            fast_read_timing_enable  <= 1'b0;
            clock_multiplier_sel_hi  <= 1'b0;
            clock_multiplier_sel_lo  <= 1'b0;
            enhanced_features_enable <= 1'b0;
            idle_line_wait_disable   <= 1'b0;
            reconfig_timeout_sel_hi  <= 1'b0;
            reconfig_timeout_sel_lo  <= 1'b0;
        end else begin
            // Read timing and multiplier.
            fast_read_timing_enable  <= setup_reg[FAST_READ_BIT];
            clock_multiplier_sel_hi  <= setup_reg[CLK_SEL_HI_BIT];
            clock_multiplier_sel_lo  <= setup_reg[CLK_SEL_LO_BIT];

            // Enhanced, idle-wait, timer.
            enhanced_features_enable <= setup_reg[ENHANCED_BIT];
            idle_line_wait_disable   <= setup_reg[IDLE_WAIT_BIT];
            reconfig_timeout_sel_hi  <= setup_reg[TIMEOUT_HI_BIT];
            reconfig_timeout_sel_lo  <= setup_reg[TIMEOUT_LO_BIT];
        end
    end

    // Timeout count follows the timer code.
    // A new code acts one cycle after the register takes it.
    // Code 11 needs node 255; it is not checked.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // Longest timeout after reset.
            reconfig_timeout_cycles <= TIMEOUT_WIDTH'(TIMEOUT_420_CYC);
        end else begin
            reconfig_timeout_cycles <= timeout_of(setup_reg[TIMEOUT_HI_BIT:TIMEOUT_LO_BIT]);
        end
    end

    // Core sequencer: a clock change halts the core until the restart command.
    // Reset alone does not halt the core.
    // A second change still recovers.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // Run after reset, PLL still off.
            state_reg           <= CORE_RUN;
            lock_count_reg      <= 12'h000;
            restart_pending_reg <= 1'b0;
        end else begin
            case (state_reg)
                // Running until a code change.
                CORE_RUN: begin
                    restart_pending_reg <= 1'b0;
                    lock_count_reg      <= 12'h000;
                    if (clock_change) begin
                        state_reg <= (new_clock_sel == CLK_SEL_40MHZ) ? CORE_LOCKING
                                                                      : CORE_WAIT_CMD;
                    end
                end

                // Measures the PLL lock span.
                CORE_LOCKING: begin
                    // A restart written during lock is kept and honoured once locked.
                    if (command_write) begin
                        restart_pending_reg <= 1'b1;
                    end
                    // Hold the last count.
                    if (lock_count_reg == LOCK_LAST) begin
                        state_reg <= CORE_WAIT_CMD;
                    end else begin
                        lock_count_reg <= lock_count_reg + 12'h001;
                    end
                end

                // Waits for the restart command.
                // A new change starts over.
                CORE_WAIT_CMD: begin
                    if (clock_change) begin
                        lock_count_reg      <= 12'h000;
                        restart_pending_reg <= 1'b0;
                        state_reg <= (new_clock_sel == CLK_SEL_40MHZ) ? CORE_LOCKING
                                                                      : CORE_WAIT_CMD;
                    end else if (command_write || restart_pending_reg) begin
                        // A kept restart counts too.
                        state_reg <= CORE_RUN;
                    end
                end

                // A bad code falls back to run.
                default: begin
                    state_reg <= CORE_RUN;
                end
            endcase
        end
    end

    // PLL power and clock selection follow the multiplier code and lock state.
    // The PLL stays off until code 01 is stored.
    // The 40 MHz select waits for lock.
    // Halted rises in the write cycle, so no
    // core cycle runs on the old clock.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // PLL off after reset.
            pll_power_up       <= 1'b0;
            pll_locked         <= 1'b0;
            clock_40mhz_select <= 1'b0;
            core_halted        <= 1'b0;
        end else begin
            // Reserved codes leave it off.
            pll_power_up <= ({setup_reg[CLK_SEL_HI_BIT], setup_reg[CLK_SEL_LO_BIT]}
                             == CLK_SEL_40MHZ);

            // Locked once the span has ended.
            pll_locked   <= (state_reg == CORE_WAIT_CMD || state_reg == CORE_RUN) &&
                            ({setup_reg[CLK_SEL_HI_BIT], setup_reg[CLK_SEL_LO_BIT]}
                             == CLK_SEL_40MHZ);

            // Move to 40 MHz only when locked.
            clock_40mhz_select <= (state_reg != CORE_LOCKING) &&
                                  ({setup_reg[CLK_SEL_HI_BIT], setup_reg[CLK_SEL_LO_BIT]}
                                   == CLK_SEL_40MHZ);

            // Halted while not running.
            core_halted <= (state_reg != CORE_RUN) || clock_change;
        end
    end

    // RAM init request is held until the line is idle, unless waiting is disabled.
    // Starts also wait while the core is halted.
    // A request meeting a start stays pending.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            init_pending_reg <= 1'b0;
            ram_init_start   <= 1'b0;
        end else begin
            ram_init_start <= 1'b0;
            // Start when the line may be written.
            if ((init_pending_reg || ram_init_request) && state_reg == CORE_RUN &&
                (setup_reg[IDLE_WAIT_BIT] || line_idle)) begin
                ram_init_start   <= 1'b1;
                init_pending_reg <= init_pending_reg && ram_init_request;
            end else if (ram_init_request) begin
                init_pending_reg <= 1'b1;
            end
        end
    end

    // Read data for the addressed register; other addresses answer zero.
    // Both read timings share it.
    always_comb begin
        read_value = 8'h00;
        if (host_req.addr == SETUP_ADDR) begin
            read_value = setup_reg;
        end
    end

    // Read pipeline: fast timing answers after one cycle, normal after two.
    // Fast timing skips the stage register.
    // A staged answer wins a same-cycle clash,
    // which needs the fast bit toggled mid-read.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // No answer pending.
            read_stage_reg       <= 8'h00;
            read_stage_valid_reg <= 1'b0;
            read_data            <= 8'h00;
            read_valid           <= 1'b0;
        end else begin
            read_stage_valid_reg <= 1'b0;
            read_valid           <= 1'b0;
            if (host_req.select && host_req.read && setup_reg[FAST_READ_BIT]) begin
                // Answer at the next edge.
                read_data  <= read_value;
                read_valid <= 1'b1;
            end else if (host_req.select && host_req.read) begin
                // Park the answer a cycle.
                read_stage_reg       <= read_value;
                read_stage_valid_reg <= 1'b1;
            end

            // The parked answer leaves.
            if (read_stage_valid_reg) begin
                read_data  <= read_stage_reg;
                read_valid <= 1'b1;
            end
        end
    end

endmodule

// file: clock_timer_setup_pkg.sv
// Purpose: Shared constants and types for the clock and timer setup register.
// Assumes: Host bus logic runs on the same 250 MHz clock as this block.
// Notes:   All offsets, field positions, resets and timing counts live here.
//
// What this block does
// - Fast read bit set shortens read answer.
// - Writes behave the same in either read mode.
// - Multiplier code 00 is 20 MHz, 01 40 MHz.
// - Multiplier stays powered down after reset until selected.
// - Multiplier change halts core; a change to 01 wakes the PLL.
// - Core stays halted until command 18H arrives.
// - Enhanced features bit enables new features; clear is legacy.
// - Idle-wait bit clear: RAM init waits for idle line.
// - Idle-wait bit set: RAM init runs without waiting.
// - Timer code selects 420, 105, 52.5, 26.25 ms timeout.
// - Bit 6 is reserved; logic ignores it.
// - Fast read enable sits at bit 7.
package clock_timer_setup_pkg;

    // Register addresses on the host register bus.
    localparam logic [2:0] SETUP_ADDR   = 3'h7;
    localparam logic [2:0] COMMAND_ADDR = 3'h1;
    localparam logic [7:0] RESTART_CMD  = 8'h18;

    // Field positions inside the setup register.
    localparam int FAST_READ_BIT  = 7;
    localparam int RESERVED_BIT   = 6;
    localparam int CLK_SEL_HI_BIT = 5;
    localparam int CLK_SEL_LO_BIT = 4;
    localparam int ENHANCED_BIT   = 3;
    localparam int IDLE_WAIT_BIT  = 2;
    localparam int TIMEOUT_HI_BIT = 1;
    localparam int TIMEOUT_LO_BIT = 0;

    // Reset value of the setup register.
    localparam logic [7:0] SETUP_RESET = 8'h00;

    // Clock multiplier codes.
    localparam logic [1:0] CLK_SEL_20MHZ = 2'h0;
    localparam logic [1:0] CLK_SEL_40MHZ = 2'h1;

    // Timing figures in their own units and their cycle counts at the block clock.
    localparam int CLOCK_MHZ           = 250;
    localparam int PLL_LOCK_US         = 8;
    localparam int PLL_LOCK_CYCLES     = PLL_LOCK_US * CLOCK_MHZ;
    localparam int TIMEOUT_420_US      = 420000;
    localparam int TIMEOUT_105_US      = 105000;
    localparam int TIMEOUT_52P5_US     = 52500;
    localparam int TIMEOUT_26P25_US    = 26250;
    localparam int TIMEOUT_420_CYCLES  = TIMEOUT_420_US * CLOCK_MHZ;
    localparam int TIMEOUT_105_CYCLES  = TIMEOUT_105_US * CLOCK_MHZ;
    localparam int TIMEOUT_52P5_CYCLES = TIMEOUT_52P5_US * CLOCK_MHZ;
    localparam int TIMEOUT_26_CYCLES   = TIMEOUT_26P25_US * CLOCK_MHZ;
    localparam int TIMEOUT_WIDTH       = 27;

    // Read latency in cycles from request to answer.
    localparam int NORMAL_READ_CYCLES = 2;
    localparam int FAST_READ_CYCLES   = 1;

    // One host bus request, sampled on the block clock.
    typedef struct packed {
        logic       select;
        logic       write;
        logic       read;
        logic [2:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // Core sequencing states.
    typedef enum logic [2:0] {
        CORE_RUN      = 3'b001,
        CORE_LOCKING  = 3'b010,
        CORE_WAIT_CMD = 3'b100
    } core_state_t;

endpackage

// file: clock_timer_setup_asserts.sv
// Purpose: Port timing checks for the clock and timer setup block.
// Assumes: One clock domain with rstn as its asynchronous reset.
// Notes:   Bound to the block from the testbench top file.
module clock_timer_setup_asserts #(
    parameter int unsigned TIMEOUT_420_CYC  = 400,
    parameter int unsigned TIMEOUT_105_CYC  = 100,
    parameter int unsigned TIMEOUT_52P5_CYC = 50,
    parameter int unsigned TIMEOUT_26_CYC   = 25
) (
    input wire logic                             clock,
    input wire logic                             rstn,
    input wire clock_timer_setup_pkg::host_req_t host_req,
    input wire logic                             line_idle,
    input wire logic                             ram_init_request,
    input wire logic                             read_valid,
    input wire logic                             fast_read_timing_enable,
    input wire logic                             idle_line_wait_disable,
    input wire logic                             reconfig_timeout_sel_hi,
    input wire logic                             reconfig_timeout_sel_lo,
    input wire logic                             pll_power_up,
    input wire logic                             pll_locked,
    input wire logic                             core_halted,
    input wire logic                             ram_init_start,
    input wire logic [clock_timer_setup_pkg::TIMEOUT_WIDTH-1:0] reconfig_timeout_cycles
);
    import clock_timer_setup_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // Decoded requests and the timeout that the stored code should give.
    logic        rd;
    logic        wr7;
    logic        cmd;
    logic [1:0]  tsel;
    int unsigned tmo_exp;
    assign rd = host_req.select && host_req.read && host_req.addr == SETUP_ADDR;
    assign wr7 = host_req.select && host_req.write && host_req.addr == SETUP_ADDR;
    assign cmd = host_req.select && host_req.write && host_req.addr == COMMAND_ADDR
                 && host_req.wdata == RESTART_CMD;
    assign tsel = {reconfig_timeout_sel_hi, reconfig_timeout_sel_lo};
    assign tmo_exp = tsel == 2'h0 ? TIMEOUT_420_CYC : tsel == 2'h1 ? TIMEOUT_105_CYC :
                     tsel == 2'h2 ? TIMEOUT_52P5_CYC : TIMEOUT_26_CYC;

    // Counts cycles spent waiting for the PLL to lock.
    logic [11:0] lock_cnt;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lock_cnt <= 12'h000;
        end else if (!pll_power_up || pll_locked) begin
            lock_cnt <= 12'h000;
        end else begin
            lock_cnt <= lock_cnt + 12'h001;
        end
    end

    // A timer code held for two cycles, and an accepted restart command.
    sequence s_timer_steady;
        $stable(tsel) [*2];
    endsequence
    sequence s_restart;
        core_halted && pll_locked && cmd;
    endsequence
    sequence s_pll_wake;
        core_halted ##1 (core_halted && pll_power_up);
    endsequence

    a_fast_read: assert property (rd && fast_read_timing_enable |=> read_valid)
        else $error("fast read answer not after one cycle");
    a_normal_read: assert property (rd && !fast_read_timing_enable |-> ##2 read_valid)
        else $error("normal read answer not after two cycles");
    a_timeout_map: assert property (s_timer_steady |-> 32'(reconfig_timeout_cycles) == tmo_exp)
        else $error("timeout count does not match timer code");
    a_halt_on_change: assert property (wr7 && host_req.wdata[5:4] == CLK_SEL_40MHZ && !pll_power_up
        |=> s_pll_wake)
        else $error("multiplier change did not halt core");
    a_lock_time: assert property ($rose(pll_locked) |-> lock_cnt >= 12'h7C6 && lock_cnt <= 12'h7DA)
        else $error("PLL lock time out of range");
    a_halt_holds: assert property (core_halted && !cmd && !$past(cmd) |=> core_halted)
        else $error("core restarted without command");
    a_cmd_restart: assert property (s_restart |-> ##[1:2] !core_halted)
        else $error("restart command did not release core");
    a_ram_waits: assert property (ram_init_start |-> $past(line_idle || idle_line_wait_disable))
        else $error("RAM init started on a busy line");
    a_ram_starts: assert property (ram_init_request && !core_halted
        && (line_idle || idle_line_wait_disable) |-> ##[1:2] ram_init_start)
        else $error("RAM init did not start");
endmodule

// file: host_model.sv
// Purpose: Host controller model driving the setup block request port.
// Assumes: Tasks are entered 1 ns after a rising edge and return likewise.
// Notes:   Models a non-multiplexed bus, so fast reads are always legal.
module host_model (
    input  wire logic                       clock,
    input  wire logic [7:0]                 read_data,
    input  wire logic                       read_valid,
    output clock_timer_setup_pkg::host_req_t host_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import clock_timer_setup_pkg::*;

    // The bus is idle from time zero.
    initial host_req = '0;

    // One write strobe, then an idle cycle so strobes never merge.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host_req <= '{1'b1, 1'b1, 1'b0, a, d};
        @(posedge clock);
        #1 host_req <= '0;
        @(posedge clock);
        #1;
    endtask

    // One read strobe on the non-multiplexed bus; n counts cycles to the answer.
    task automatic rd(input logic [2:0] a, output logic [7:0] d, output int n);
        host_req <= '{1'b1, 1'b0, 1'b1, a, 8'h00};
        @(posedge clock);
        #1 host_req <= '0;
        n = 1;
        while (read_valid !== 1'b1 && n < 4) begin
            @(posedge clock);
            #1 n++;
        end
        d = read_data;
    endtask
endmodule

// file: test_clock_timer_setup.sv
// Purpose: Self-checking testbench for the clock and timer setup block.
// Assumes: Stimulus changes 1 ns after each rising edge.
// Notes:   Timeouts shrink to 400, 100, 50, 25 cycles; the settle wait to 2100.
module test_clock_timer_setup;
    timeunit 1ns;
    timeprecision 1ps;
    import clock_timer_setup_pkg::*;

    localparam int unsigned TMO [4] = '{400, 100, 50, 25};
    logic                     clock;
    logic                     rstn;
    logic                     line_idle;
    logic                     ram_init_request;
    host_req_t                host_req;
    logic [7:0]               read_data;
    logic [7:0]               fields;
    logic [TIMEOUT_WIDTH-1:0] reconfig_timeout_cycles;
    logic read_valid, fast_read_timing_enable, clock_multiplier_sel_hi, clock_multiplier_sel_lo;
    logic enhanced_features_enable, idle_line_wait_disable, reconfig_timeout_sel_hi;
    logic reconfig_timeout_sel_lo, pll_power_up, pll_locked, clock_40mhz_select, core_halted;
    logic ram_init_start;
    int   bad_count = 0;
    int   num_checks = 0;
    int   starts = 0;

    // Field outputs gathered in register order, bit 6 left clear.
    assign fields = {fast_read_timing_enable, 1'b0, clock_multiplier_sel_hi,
                     clock_multiplier_sel_lo, enhanced_features_enable, idle_line_wait_disable,
                     reconfig_timeout_sel_hi, reconfig_timeout_sel_lo};

    clock_timer_setup #(.TIMEOUT_420_CYC(TMO[0]), .TIMEOUT_105_CYC(TMO[1]),
        .TIMEOUT_52P5_CYC(TMO[2]), .TIMEOUT_26_CYC(TMO[3])) uut (
        .clock, .rstn, .host_req, .line_idle, .ram_init_request, .read_data, .read_valid,
        .fast_read_timing_enable, .clock_multiplier_sel_hi, .clock_multiplier_sel_lo,
        .enhanced_features_enable, .idle_line_wait_disable, .reconfig_timeout_sel_hi,
        .reconfig_timeout_sel_lo, .pll_power_up, .pll_locked, .clock_40mhz_select,
        .core_halted, .ram_init_start, .reconfig_timeout_cycles);
    host_model h (.clock, .read_data, .read_valid, .host_req);

    // A 250 MHz clock, and a count of RAM init starts.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        if (ram_init_start === 1'b1) begin
            starts <= starts + 1;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        tick(3);
        rstn <= 1'b1;
    endtask

    task automatic ram_req();
        ram_init_request <= 1'b1;
        tick(1);
        ram_init_request <= 1'b0;
    endtask

    // Reset values, seen at the ports and through a normal read.
    task automatic chk_reset();
        logic [7:0] d;
        int         n;
        h.rd(SETUP_ADDR, d, n);
        check(d, SETUP_RESET);
        check(n, NORMAL_READ_CYCLES);
        check(fields, 8'h00);
        check(pll_power_up, 0);
        check(reconfig_timeout_cycles, TMO[0]);
    endtask

    // Main sequence of tests.
    initial begin
        logic [7:0] d;
        logic [7:0] v;
        int         n;
        rstn = 1'b0;
        line_idle = 1'b0;
        ram_init_request = 1'b0;
        do_reset();
        chk_reset();
        $display("Test reset values done");
        for (int c = 0; c < 4; c++) begin
            v = 8'(5 * c);
            h.wr(SETUP_ADDR, v | 8'h40); // Node 255 is taken as present.
            h.rd(SETUP_ADDR, d, n);
            check(d, v);
            check(fields, v);
            check(reconfig_timeout_cycles, TMO[c]);
        end
        $display("Test timer codes done");
        h.wr(SETUP_ADDR, 8'h88);
        h.rd(SETUP_ADDR, d, n);
        check(n, FAST_READ_CYCLES);
        h.wr(SETUP_ADDR, 8'hCA);
        h.rd(SETUP_ADDR, d, n);
        check(d, 8'h8A);
        check(reconfig_timeout_cycles, TMO[2]);
        $display("Test fast read done");
        ram_req();
        tick(5);
        check(starts, 0);
        line_idle <= 1'b1;
        tick(3);
        check(starts, 1);
        line_idle <= 1'b0;
        h.wr(SETUP_ADDR, 8'h8E);
        ram_req();
        tick(3);
        check(starts, 2);
        $display("Test RAM init done");
        h.wr(SETUP_ADDR, 8'h9A); // Single change in this reset.
        check(core_halted, 1);
        check(pll_power_up, 1);
        check(clock_multiplier_sel_lo, 1);
        h.wr(COMMAND_ADDR, 8'h08);
        tick(2100);
        check(pll_locked, 1);
        check(clock_40mhz_select, 1);
        check(core_halted, 1);
        h.wr(COMMAND_ADDR, RESTART_CMD);
        tick(1);
        check(core_halted, 0);
        $display("Test clock change done");
        do_reset();
        chk_reset();
        $display("Test second reset done");
        stop_test();
    end

    // The tests take under 2500 cycles; this limit allows eight times that.
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        stop_test();
    end
endmodule

bind clock_timer_setup clock_timer_setup_asserts #(
    .TIMEOUT_420_CYC(TIMEOUT_420_CYC), .TIMEOUT_105_CYC(TIMEOUT_105_CYC),
    .TIMEOUT_52P5_CYC(TIMEOUT_52P5_CYC), .TIMEOUT_26_CYC(TIMEOUT_26_CYC)) chk (
    .clock, .rstn, .host_req, .line_idle, .ram_init_request, .read_valid,
    .fast_read_timing_enable, .idle_line_wait_disable, .reconfig_timeout_sel_hi,
    .reconfig_timeout_sel_lo, .pll_power_up, .pll_locked, .core_halted, .ram_init_start,
    .reconfig_timeout_cycles);
